// ### rtl/dmc_mode_regs.sv
// Mode-control register bank of a stereo audio converter: attenuation, format, emphasis, mute and mode bits.
// Assumes the serial control port deserialiser hands over whole 16-bit access words on clk, and that the
// zero detect inputs come from datapath logic on clk. The word clock pin is asynchronous and is synchronised here.
//
// Summary of operation
// - Top bit 0 writes, 1 reads back.
// - Gain is 0.5 dB times code minus 255.
// - Codes 0-14 mute; code 15 is -120 dB.
// - Both gain codes reset to all ones.
// - Channels separate; one shared load enable.
// - Load enable low keeps old applied levels.
// - Load enable high loads written codes normally.
// - Three-bit field picks serial audio format.
// - Two-bit field picks de-emphasis sample rate.
// - One-bit-stream mode: field picks FIR setting.
// - Emphasis enable switches both channels together; not one-bit-stream.
// - Soft mute ramps 255 steps from full scale to code 0.
// - Step every 1, 2, 4, 8 word clocks.
// - Phase invert flips both channels' polarity.
// - Output disable forces bipolar zero level.
// - Rolloff bit: 0 sharp, 1 slow.
// - Zero-hold mute on both-zero; not one-bit-stream.
// - Write-only reset bit fires one pulse.
// - Mode bit enables one-bit-stream interface.
// - Bypass bit skips internal interpolation filter.
// - In bypass, format field means external format.
`timescale 1ns/1ps
`include "dmc_params.svh"

module dmc_mode_regs (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        access_valid,
  input  wire logic [15:0] access_word,
  input  wire logic        word_clock,
  input  wire logic        zero_detect_left,
  input  wire logic        zero_detect_right,
  output logic      [7:0]  read_data,
  output logic             read_valid,
  output logic      [7:0]  left_gain_code,
  output logic      [7:0]  right_gain_code,
  output logic             left_gain_mute,
  output logic             right_gain_mute,
  output logic      [2:0]  audio_format_select,
  output logic      [2:0]  ext_filter_format,
  output logic      [1:0]  emphasis_rate_select,
  output logic      [1:0]  fir_perf_select,
  output logic             emphasis_enable,
  output logic             phase_invert,
  output logic             output_disable,
  output logic             bipolar_zero_level,
  output logic             rolloff_select,
  output logic             zero_hold_mute,
  output logic             one_bit_stream_mode,
  output logic             filter_bypass,
  output logic             soft_system_reset
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Access word fields.
  logic                     acc_read;
  logic [6:0]               acc_idx;
  dmc_pkg::dmc_code_t       acc_data;
  logic                     acc_write;

  assign acc_read  = access_word[`DMC_RW_BIT];
  assign acc_idx   = access_word[`DMC_IDX_MSB:`DMC_IDX_LSB];
  assign acc_data  = access_word[`DMC_DATA_MSB:0];
  assign acc_write = access_valid && !acc_read;

  // Register state.
  dmc_pkg::dmc_code_t left_reg,  left_next;
  dmc_pkg::dmc_code_t right_reg, right_next;
  dmc_pkg::dmc_code_t left_target_reg,  left_target_next;
  dmc_pkg::dmc_code_t right_target_reg, right_target_next;
  logic [7:0]         fmt_ctrl_reg, fmt_ctrl_next;
  logic [7:0]         out_ctrl_reg, out_ctrl_next;
  logic [7:0]         sys_ctrl_reg, sys_ctrl_next;
  logic               soft_system_reset_pulse_reg, soft_system_reset_pulse_next;
  logic [7:0]         read_data_reg, read_data_next;
  logic               read_valid_reg, read_valid_next;

  // Register writes, readback and the soft reset. The reset pulse returns every register to its default on the
  // same edge it leaves, so software sees defaults from the cycle after the pulse.
  always_comb begin
    left_next         = left_reg;
    right_next        = right_reg;
    left_target_next  = left_target_reg;
    right_target_next = right_target_reg;
    fmt_ctrl_next     = fmt_ctrl_reg;
    out_ctrl_next     = out_ctrl_reg;
    sys_ctrl_next     = sys_ctrl_reg;
    soft_system_reset_pulse_next   = 1'b0;
    read_data_next    = read_data_reg;
    read_valid_next   = 1'b0;
    if (soft_system_reset_pulse_reg) begin
      left_next         = `DMC_GAIN_RESET;
      right_next        = `DMC_GAIN_RESET;
      left_target_next  = `DMC_GAIN_RESET;
      right_target_next = `DMC_GAIN_RESET;
      fmt_ctrl_next     = `DMC_FMT_CTRL_RESET;
      out_ctrl_next     = `DMC_OUT_CTRL_RESET;
      sys_ctrl_next     = `DMC_SYS_CTRL_RESET;
    end else if (acc_write) begin
      case (acc_idx)
        `DMC_IDX_LEFT: begin
          left_next = acc_data;
          if (fmt_ctrl_reg[`DMC_LOAD_BIT]) begin
            left_target_next = acc_data;
          end
        end
        `DMC_IDX_RIGHT: begin
          right_next = acc_data;
          if (fmt_ctrl_reg[`DMC_LOAD_BIT]) begin
            right_target_next = acc_data;
          end
        end
        `DMC_IDX_FMT_CTRL: fmt_ctrl_next = acc_data;
        `DMC_IDX_OUT_CTRL: out_ctrl_next = acc_data & `DMC_OUT_CTRL_MASK;
        `DMC_IDX_SYS_CTRL: begin
          sys_ctrl_next   = acc_data & `DMC_SYS_CTRL_MASK;
          soft_system_reset_pulse_next = acc_data[`DMC_SOFT_SYSTEM_RESET_BIT];
        end
        default: ;
      endcase
    end
    if (access_valid && acc_read) begin
      read_valid_next = 1'b1;
      case (acc_idx)
        `DMC_IDX_LEFT:     read_data_next = left_reg;
        `DMC_IDX_RIGHT:    read_data_next = right_reg;
        `DMC_IDX_FMT_CTRL: read_data_next = fmt_ctrl_reg;
        `DMC_IDX_OUT_CTRL: read_data_next = out_ctrl_reg;
        `DMC_IDX_SYS_CTRL: read_data_next = sys_ctrl_reg;
        default:           read_data_next = `DMC_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      left_reg         <= `DMC_GAIN_RESET;
      right_reg        <= `DMC_GAIN_RESET;
      left_target_reg  <= `DMC_GAIN_RESET;
      right_target_reg <= `DMC_GAIN_RESET;
      fmt_ctrl_reg     <= `DMC_FMT_CTRL_RESET;
      out_ctrl_reg     <= `DMC_OUT_CTRL_RESET;
      sys_ctrl_reg     <= `DMC_SYS_CTRL_RESET;
      soft_system_reset_pulse_reg   <= 1'b0;
      read_data_reg    <= `DMC_READ_ZERO;
      read_valid_reg   <= 1'b0;
    end else begin
      left_reg         <= left_next;
      right_reg        <= right_next;
      left_target_reg  <= left_target_next;
      right_target_reg <= right_target_next;
      fmt_ctrl_reg     <= fmt_ctrl_next;
      out_ctrl_reg     <= out_ctrl_next;
      sys_ctrl_reg     <= sys_ctrl_next;
      soft_system_reset_pulse_reg   <= soft_system_reset_pulse_next;
      read_data_reg    <= read_data_next;
      read_valid_reg   <= read_valid_next;
    end
  end

  // Word clock synchroniser and step rate divider.
  logic       wc_meta_reg, wc_meta_next;
  logic       wc_sync_reg, wc_sync_next;
  logic       wc_prev_reg, wc_prev_next;
  logic [2:0] step_cnt_reg, step_cnt_next;
  logic       step_tick_reg, step_tick_next;
  logic       wc_edge;
  logic [2:0] rate_mask;

  // The edge detector reads only the second and third stages, never the metastable first one.
  always_comb begin
    wc_meta_next  = word_clock;
    wc_sync_next  = wc_meta_reg;
    wc_prev_next  = wc_sync_reg;
    wc_edge       = wc_sync_reg && !wc_prev_reg;
    unique case (dmc_pkg::dmc_step_rate_t'(out_ctrl_reg[`DMC_ATS_MSB:`DMC_ATS_LSB]))
      dmc_pkg::DMC_STEP_EVERY:   rate_mask = `DMC_RATE_MASK_1;
      dmc_pkg::DMC_STEP_HALF:    rate_mask = `DMC_RATE_MASK_2;
      dmc_pkg::DMC_STEP_QUARTER: rate_mask = `DMC_RATE_MASK_4;
      dmc_pkg::DMC_STEP_EIGHTH:  rate_mask = `DMC_RATE_MASK_8;
    endcase
    step_cnt_next  = wc_edge ? step_cnt_reg + 3'h1 : step_cnt_reg;
    step_tick_next = wc_edge && ((step_cnt_reg & rate_mask) == rate_mask);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wc_meta_reg   <= 1'b0;
      wc_sync_reg   <= 1'b0;
      wc_prev_reg   <= 1'b0;
      step_cnt_reg  <= 3'h0;
      step_tick_reg <= 1'b0;
    end else begin
      wc_meta_reg   <= wc_meta_next;
      wc_sync_reg   <= wc_sync_next;
      wc_prev_reg   <= wc_prev_next;
      step_cnt_reg  <= step_cnt_next;
      step_tick_reg <= step_tick_next;
    end
  end

  // Soft mute drives both ramps toward code 0; otherwise they follow the last loaded code.
  dmc_pkg::dmc_code_t left_goal;
  dmc_pkg::dmc_code_t right_goal;
  dmc_pkg::dmc_code_t left_level;
  dmc_pkg::dmc_code_t right_level;

  assign left_goal  = fmt_ctrl_reg[`DMC_MUTE_BIT] ? 8'h00 : left_target_reg;
  assign right_goal = fmt_ctrl_reg[`DMC_MUTE_BIT] ? 8'h00 : right_target_reg;

  dmc_gain_ramp #(.W(8), .RESET_CODE(`DMC_GAIN_RESET)) u_left_ramp (
    .clk     (clk),
    .resetn  (resetn),
    .restart (soft_system_reset_pulse_reg),
    .step    (step_tick_reg),
    .target  (left_goal),
    .level   (left_level)
  );

  dmc_gain_ramp #(.W(8), .RESET_CODE(`DMC_GAIN_RESET)) u_right_ramp (
    .clk     (clk),
    .resetn  (resetn),
    .restart (soft_system_reset_pulse_reg),
    .step    (step_tick_reg),
    .target  (right_goal),
    .level   (right_level)
  );

  // Derived mode outputs, registered so every port leaves a flip-flop.
  logic       left_mute_reg, left_mute_next;
  logic       right_mute_reg, right_mute_next;
  logic [2:0] pcm_fmt_reg, pcm_fmt_next;
  logic [2:0] ext_fmt_reg, ext_fmt_next;
  logic [1:0] emph_rate_reg, emph_rate_next;
  logic [1:0] fir_perf_reg, fir_perf_next;
  logic       emph_en_reg, emph_en_next;
  logic       zero_hold_reg, zero_hold_next;
  logic       bpz_reg, bpz_next;
  logic       dsd_mode;
  logic       bypass_mode;

  assign dsd_mode    = sys_ctrl_reg[`DMC_DSD_BIT];
  assign bypass_mode = sys_ctrl_reg[`DMC_FILTER_BYPASS_BIT];

  // In bypass the format field belongs to the external filter, so the PCM format keeps its last value.
  always_comb begin
    left_mute_next  = (left_level <= `DMC_MUTE_LAST_CODE);
    right_mute_next = (right_level <= `DMC_MUTE_LAST_CODE);
    pcm_fmt_next    = bypass_mode ? pcm_fmt_reg : fmt_ctrl_reg[`DMC_FMT_MSB:`DMC_FMT_LSB];
    ext_fmt_next    = bypass_mode ? fmt_ctrl_reg[`DMC_FMT_MSB:`DMC_FMT_LSB] : 3'h0;
    emph_rate_next  = dsd_mode ? 2'h0 : fmt_ctrl_reg[`DMC_DMF_MSB:`DMC_DMF_LSB];
    fir_perf_next   = dsd_mode ? fmt_ctrl_reg[`DMC_DMF_MSB:`DMC_DMF_LSB] : 2'h0;
    emph_en_next    = fmt_ctrl_reg[`DMC_DME_BIT] && !dsd_mode;
    zero_hold_next  = out_ctrl_reg[`DMC_ZERO_HOLD_MUTE_ENABLE_BIT] && !dsd_mode
                      && zero_detect_left && zero_detect_right;
    bpz_next        = out_ctrl_reg[`DMC_OPE_BIT] || zero_hold_next;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      left_mute_reg  <= 1'b0;
      right_mute_reg <= 1'b0;
      pcm_fmt_reg    <= 3'(`DMC_FMT_CTRL_RESET >> `DMC_FMT_LSB);
      ext_fmt_reg    <= 3'h0;
      emph_rate_reg  <= 2'h0;
      fir_perf_reg   <= 2'h0;
      emph_en_reg    <= 1'b0;
      zero_hold_reg  <= 1'b0;
      bpz_reg        <= 1'b0;
    end else begin
      left_mute_reg  <= left_mute_next;
      right_mute_reg <= right_mute_next;
      pcm_fmt_reg    <= pcm_fmt_next;
      ext_fmt_reg    <= ext_fmt_next;
      emph_rate_reg  <= emph_rate_next;
      fir_perf_reg   <= fir_perf_next;
      emph_en_reg    <= emph_en_next;
      zero_hold_reg  <= zero_hold_next;
      bpz_reg        <= bpz_next;
    end
  end

  // Port assignments, all from flip-flops.
  assign read_data            = read_data_reg;
  assign read_valid           = read_valid_reg;
  assign left_gain_code       = left_level;
  assign right_gain_code      = right_level;
  assign left_gain_mute       = left_mute_reg;
  assign right_gain_mute      = right_mute_reg;
  assign audio_format_select  = pcm_fmt_reg;
  assign ext_filter_format    = ext_fmt_reg;
  assign emphasis_rate_select = emph_rate_reg;
  assign fir_perf_select      = fir_perf_reg;
  assign emphasis_enable      = emph_en_reg;
  assign phase_invert         = out_ctrl_reg[`DMC_REV_BIT];
  assign output_disable       = out_ctrl_reg[`DMC_OPE_BIT];
  assign bipolar_zero_level   = bpz_reg;
  assign rolloff_select       = out_ctrl_reg[`DMC_FLT_BIT];
  assign zero_hold_mute       = zero_hold_reg;
  assign one_bit_stream_mode  = dsd_mode;
  assign filter_bypass        = bypass_mode;
  assign soft_system_reset    = soft_system_reset_pulse_reg;

  // A write to the left register stores the data on the next edge.
  property p_write_stores;
    (acc_write && (acc_idx == `DMC_IDX_LEFT) && !soft_system_reset_pulse_reg) |=> (left_reg == $past(acc_data));
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("left register write not stored");

  // A read answers one cycle later with the stored value.
  property p_read_back;
    (access_valid && acc_read && (acc_idx == `DMC_IDX_RIGHT)) |=> read_valid && (read_data == $past(right_reg));
  endproperty
  a_read_back: assert property (p_read_back) else $error("readback wrong or late");

  // Leaving reset both gain codes read as full scale.
  property p_reset_gain;
    $rose(resetn) |-> (left_reg == `DMC_GAIN_RESET) && (right_gain_code == `DMC_GAIN_RESET);
  endproperty
  a_reset_gain: assert property (p_reset_gain) else $error("gain code not full scale after reset");

  // With the load enable clear a new code never reaches the applied target.
  property p_load_blocked;
    (acc_write && (acc_idx == `DMC_IDX_LEFT) && !fmt_ctrl_reg[`DMC_LOAD_BIT] && !soft_system_reset_pulse_reg)
      |=> $stable(left_target_reg);
  endproperty
  a_load_blocked: assert property (p_load_blocked) else $error("code loaded while load enable clear");

  // With the load enable set the code becomes the right channel's target.
  property p_load_taken;
    (acc_write && (acc_idx == `DMC_IDX_RIGHT) && fmt_ctrl_reg[`DMC_LOAD_BIT] && !soft_system_reset_pulse_reg)
      |=> (right_target_reg == $past(acc_data)) && $stable(left_target_reg);
  endproperty
  a_load_taken: assert property (p_load_taken) else $error("code not loaded while load enable set");

  // Mute flag follows the applied code: 14 and below mute, 15 does not.
  property p_mute_edge;
    (left_level <= `DMC_MUTE_LAST_CODE) |=> left_gain_mute;
  endproperty
  a_mute_edge: assert property (p_mute_edge) else $error("low code not flagged as mute");

  property p_finite_floor;
    (left_level == `DMC_MUTE_LAST_CODE + 8'h01) |=> !left_gain_mute;
  endproperty
  a_finite_floor: assert property (p_finite_floor) else $error("code 15 flagged as mute");

  // At the slowest rate a step falls only on every eighth word clock edge.
  property p_rate_eighth;
    (step_tick_reg && $past(out_ctrl_reg[`DMC_ATS_MSB:`DMC_ATS_LSB]) == 2'h3) |-> ($past(step_cnt_reg) == 3'h7);
  endproperty
  a_rate_eighth: assert property (p_rate_eighth) else $error("step at wrong word clock count");

  // Both-zero with the enable set holds bipolar zero, unless one-bit-stream mode is on.
  property p_zero_hold;
    (out_ctrl_reg[`DMC_ZERO_HOLD_MUTE_ENABLE_BIT] && zero_detect_left && zero_detect_right)
      |=> (zero_hold_mute && bipolar_zero_level) == !$past(dsd_mode);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero hold mute wrong");

  // The system reset write gives exactly one pulse, then defaults.
  sequence s_reset_pulse;
    soft_system_reset ##1 (!soft_system_reset && (left_reg == `DMC_GAIN_RESET) && !filter_bypass);
  endsequence
  property p_one_pulse;
    (acc_write && (acc_idx == `DMC_IDX_SYS_CTRL) && acc_data[`DMC_SOFT_SYSTEM_RESET_BIT] && !soft_system_reset_pulse_reg) |=> s_reset_pulse;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("system reset pulse wrong");

  // Reserved bits of the output register read as zero.
  property p_reserved_zero;
    (access_valid && acc_read && (acc_idx == `DMC_IDX_OUT_CTRL)) |=> (read_data[3:2] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read non-zero");

endmodule // dmc_mode_regs

// ### pkg/dmc_params.svh
// Constants of the mode-control register bank: access word layout, register indices, field positions,
// reset values and soft-mute step rate masks. Included by the register bank and its gain ramp.
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH

// Access word layout.
`define DMC_RW_BIT          15
`define DMC_IDX_MSB         14
`define DMC_IDX_LSB         8
`define DMC_DATA_MSB        7

// Register indices.
`define DMC_IDX_LEFT        7'h10
`define DMC_IDX_RIGHT       7'h11
`define DMC_IDX_FMT_CTRL    7'h12
`define DMC_IDX_OUT_CTRL    7'h13
`define DMC_IDX_SYS_CTRL    7'h14

// Reset values and writable-bit masks.
`define DMC_GAIN_RESET      8'hFF
`define DMC_MUTE_LAST_CODE  8'h0E
`define DMC_FMT_CTRL_RESET  8'h50
`define DMC_OUT_CTRL_RESET  8'h00
`define DMC_SYS_CTRL_RESET  8'h00
`define DMC_OUT_CTRL_MASK   8'hF3
`define DMC_SYS_CTRL_MASK   8'h30
`define DMC_READ_ZERO       8'h00

// Format, emphasis and mute register fields.
`define DMC_LOAD_BIT        7
`define DMC_FMT_MSB         6
`define DMC_FMT_LSB         4
`define DMC_DMF_MSB         3
`define DMC_DMF_LSB         2
`define DMC_DME_BIT         1
`define DMC_MUTE_BIT        0

// Output and filter register fields.
`define DMC_REV_BIT         7
`define DMC_ATS_MSB         6
`define DMC_ATS_LSB         5
`define DMC_OPE_BIT         4
`define DMC_FLT_BIT         1
`define DMC_ZERO_HOLD_MUTE_ENABLE_BIT        0

// System mode register fields.
`define DMC_SOFT_SYSTEM_RESET_BIT        6
`define DMC_DSD_BIT         5
`define DMC_FILTER_BYPASS_BIT        4

// Word clock edge masks for the four step rates.
`define DMC_RATE_MASK_1     3'h0
`define DMC_RATE_MASK_2     3'h1
`define DMC_RATE_MASK_4     3'h3
`define DMC_RATE_MASK_8     3'h7

`endif

// ### pkg/dmc_pkg.sv
// Types used by the mode-control register bank; its gain ramp uses plain vectors.
// Constants live in dmc_params.svh; this package holds types only.
package dmc_pkg;

  // One attenuation code, 0.5 dB per count below full scale.
  typedef logic [7:0] dmc_code_t;

  // Soft-mute and level-transition step rate in word clocks per step.
  typedef enum logic [1:0] {
    DMC_STEP_EVERY,
    DMC_STEP_HALF,
    DMC_STEP_QUARTER,
    DMC_STEP_EIGHTH
  } dmc_step_rate_t;

endpackage

// ### rtl/dmc_gain_ramp.sv
// One channel's applied attenuation level, walking one code per step toward its target.
// Assumes step is a one-cycle pulse on clk and restart a one-cycle soft reset pulse.
`timescale 1ns/1ps
`include "dmc_params.svh"

module dmc_gain_ramp #(
  parameter int                W          = 8,
  parameter logic [W-1:0]      RESET_CODE = `DMC_GAIN_RESET
) (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            restart,
  input  wire logic            step,
  input  wire logic [W-1:0]    target,
  output logic      [W-1:0]    level
);

  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  // Moving one code per step avoids zipper noise on large jumps.
  always_comb begin
    level_next = level_reg;
    if (restart) begin
      level_next = RESET_CODE;
    end else if (step && (level_reg < target)) begin
      level_next = level_reg + W'(1);
    end else if (step && (level_reg > target)) begin
      level_next = level_reg - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      level_reg <= RESET_CODE;
    end else begin
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

  // Outside a restart the level never jumps by more than one code and only moves on a step.
  property p_one_code_per_step;
    @(posedge clk) disable iff (!resetn)
      (!restart && (level_reg != level_next)) |->
        step && ((level_next == level_reg + W'(1)) || (level_next == level_reg - W'(1)));
  endproperty
  a_one_code_per_step: assert property (p_one_code_per_step) else $error("gain ramp moved without a single step");

endmodule // dmc_gain_ramp

// ### sim/dmc_host.sv
// Host side of the control port: issues whole access words and drives the word clock pin.
// Assumes the bench calls its tasks and that the register bank samples on rising clk.
`timescale 1ns/1ps

module dmc_host (
  input  wire logic        clk,
  output logic             access_valid,
  output logic [15:0]      access_word,
  output logic             word_clock
);
  // Idle lines start low; the word clock stands still between ticks.
  initial begin
    access_valid = 1'b0;
    access_word  = 16'h0000;
    word_clock   = 1'b0;
  end

  // One access: word held for exactly one taken edge, then scrambled so stale data never looks valid.
  task automatic xfer(input logic rw, input logic [6:0] idx, input logic [7:0] d);
    @(posedge clk);
    #1;
    access_valid = 1'b1;
    access_word  = {rw, idx, d};
    @(posedge clk);
    #1;
    access_valid = 1'b0;
    access_word  = ~access_word;
  endtask

  // Word clock periods of eight clk cycles, long enough for the pin synchroniser.
  task automatic tick(input int n);
    repeat (n) begin
      word_clock = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      word_clock = 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
endmodule // dmc_host

// ### sim/dac_mode_control_registers_bench.sv
// Self-checking bench for the mode-control register bank with a register model in the bench.
// Assumes dmc_host drives the access port and word clock; the bench drives reset and zero flags.
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fail_count++; \
  $display("Error %s exp %0h got %0h", n, e, s); end end

module dac_mode_control_registers_bench;
  logic clk = 1'b0, resetn = 1'b0, zero_detect_left = 1'b0, zero_detect_right = 1'b0;
  logic access_valid, word_clock, read_valid, left_gain_mute, right_gain_mute, emphasis_enable;
  logic phase_invert, output_disable, bipolar_zero_level, rolloff_select, zero_hold_mute;
  logic one_bit_stream_mode, filter_bypass, soft_system_reset;
  logic [15:0] access_word;
  logic [7:0]  read_data, left_gain_code, right_gain_code, mdl[5];
  logic [2:0]  audio_format_select, ext_filter_format;
  logic [1:0]  emphasis_rate_select, fir_perf_select;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  localparam logic [7:0] MSK[5] = '{8'hFF, 8'hFF, 8'hFF, 8'hF3, 8'h30};
  localparam logic [7:0] DEF[5] = '{8'hFF, 8'hFF, 8'h50, 8'h00, 8'h00};

  dmc_mode_regs i_dut (.clk, .resetn, .access_valid, .access_word, .word_clock, .zero_detect_left,
    .zero_detect_right, .read_data, .read_valid, .left_gain_code, .right_gain_code, .left_gain_mute,
    .right_gain_mute, .audio_format_select, .ext_filter_format, .emphasis_rate_select, .fir_perf_select,
    .emphasis_enable, .phase_invert, .output_disable, .bipolar_zero_level, .rolloff_select,
    .zero_hold_mute, .one_bit_stream_mode, .filter_bypass, .soft_system_reset);
  dmc_host host (.clk, .access_valid, .access_word, .word_clock);

  // Free-running clock and a hang guard well above the expected run length.
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Write keeps the model in step; reserved bits are dropped by the mask.
  task automatic w(input int i, input logic [7:0] d);
    host.xfer(1'b0, 7'(i), d);
    mdl[i-16] = d & MSK[i-16];
  endtask

  // Read answer is present right after the taken edge.
  task automatic r(input int i);
    host.xfer(1'b1, 7'(i), 8'h00);
    `CHK("rvalid", 1'b1, read_valid)
    `CHK("rdata", (i > 15 && i < 21) ? mdl[i-16] : 8'h00, read_data)
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  // Main sequence: defaults, random readback, soft reset, fields, gain ramp, mute and mode bits.
  initial begin
    void'($urandom(45));
    mdl = DEF;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    `CHK("left", 8'hFF, left_gain_code)
    `CHK("fmt", 3'b101, audio_format_select)
    for (int i = 16; i < 22; i++) r(i);
    r(32);
    repeat (3) for (int i = 16; i < 21; i++) begin
      w(i, 8'($urandom) & ((i == 20) ? 8'hBF : 8'hFF));
      r(i);
    end
    w(20, 8'h40);
    `CHK("soft_system_reset", 1'b1, soft_system_reset)
    settle();
    `CHK("soft_system_reset", 1'b0, soft_system_reset)
    mdl = DEF;
    for (int i = 16; i < 21; i++) r(i);
    for (int f = 0; f < 8; f++) begin
      w(18, {1'b0, 3'(f), 4'h0});
      settle();
      `CHK("fmt", 3'(f), audio_format_select)
    end
    for (int e = 0; e < 4; e++) begin
      w(18, {4'h5, 2'(e), 2'b10});
      settle();
      `CHK("dmf", 2'(e), emphasis_rate_select)
      `CHK("dme", 1'b1, emphasis_enable)
    end
    w(19, 8'h92);
    settle();
    `CHK("rev", 1'b1, phase_invert)
    `CHK("ope", 1'b1, output_disable)
    `CHK("bpz", 1'b1, bipolar_zero_level)
    `CHK("flt", 1'b1, rolloff_select)
    w(19, 8'h00);
    w(18, 8'h50);
    w(16, 8'h80);
    host.tick(2);
    `CHK("left", 8'hFF, left_gain_code)
    w(18, 8'hD0);
    w(16, 8'hF0);
    w(17, 8'hFE);
    host.tick(4);
    repeat (4) settle();
    `CHK("left", 8'hFB, left_gain_code)
    `CHK("right", 8'hFE, right_gain_code)
    w(19, 8'h20);
    host.tick(4);
    repeat (4) settle();
    `CHK("left", 8'hF9, left_gain_code)
    w(19, 8'h60);
    host.tick(8);
    repeat (4) settle();
    `CHK("left", 8'hF8, left_gain_code)
    w(19, 8'h00);
    w(18, 8'hDD);
    host.tick(250);
    repeat (4) settle();
    `CHK("left", 8'h00, left_gain_code)
    `CHK("lmute", 1'b1, left_gain_mute)
    `CHK("rmute", 1'b1, right_gain_mute)
    w(19, 8'h01);
    zero_detect_left = 1'b1;
    zero_detect_right = 1'b1;
    repeat (3) settle();
    `CHK("zhold", 1'b1, zero_hold_mute)
    `CHK("bpz", 1'b1, bipolar_zero_level)
    w(20, 8'h30);
    repeat (2) settle();
    `CHK("zhold", 1'b0, zero_hold_mute)
    `CHK("obs", 1'b1, one_bit_stream_mode)
    `CHK("fir", 2'b11, fir_perf_select)
    `CHK("dmf", 2'b00, emphasis_rate_select)
    `CHK("byp", 1'b1, filter_bypass)
    `CHK("extf", 3'b101, ext_filter_format)
    test_done();
  end
endmodule // dac_mode_control_registers_bench
